// File: verilog/flash_fetch_pkg.sv
package flash_fetch_pkg;

  // ==========================================================================
  // Clock and serial rate
  // ==========================================================================
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          SCK_SLOW_HZ   = 30_000_000;
  localparam int          SCK_FAST_HZ   = 60_000_000;
  // Half period is a least time, so the division rounds up
  localparam int          HALF_SLOW_CYC = (CLK_HZ + 2 * SCK_SLOW_HZ - 1) / (2 * SCK_SLOW_HZ);
  localparam int          HALF_FAST_CYC = (CLK_HZ + 2 * SCK_FAST_HZ - 1) / (2 * SCK_FAST_HZ);
  localparam logic [3:0]  HALF_SLOW_LD  = 4'((HALF_SLOW_CYC < 1 ? 1 : HALF_SLOW_CYC) - 1);
  localparam logic [3:0]  HALF_FAST_LD  = 4'((HALF_FAST_CYC < 1 ? 1 : HALF_FAST_CYC) - 1);

  // ==========================================================================
  // Flash opcodes and boot image
  // ==========================================================================
  localparam logic [7:0]  OP_FAST_READ   = 8'h0b;
  localparam logic [7:0]  OP_DUAL_READ   = 8'h3b;
  localparam logic [31:0] BOOT_SIG       = 32'h32444655;
  localparam logic [23:0] BOOT_SIG_ADDR  = 24'h00fffa;
  localparam logic [23:0] CODE_START     = 24'h000000;
  localparam logic [6:0]  DUAL_ADDR_HIGH = 7'h00;

  // ==========================================================================
  // Frame lengths
  // ==========================================================================
  localparam logic [10:0] HDR_BITS       = 11'h028;
  localparam logic [10:0] RX_BITS_SINGLE = 11'h008;
  localparam logic [10:0] RX_BITS_DUAL   = 11'h004;
  localparam logic [5:0]  CACHE_BYTES    = 6'h20;
  localparam int          CMD_BYTES      = 8;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0]  ADDR_PORT_CONTROL = 8'h00;
  localparam logic [7:0]  ADDR_UTIL_CONFIG  = 8'h04;
  localparam logic [7:0]  ADDR_FR_OPCODE    = 8'h08;
  localparam logic [7:0]  ADDR_CMD_LEN      = 8'h0c;
  localparam logic [7:0]  ADDR_CMD_BUF      = 8'h20;
  localparam logic [7:0]  ADDR_RESP_BUF     = 8'h40;
  localparam logic [7:0]  BUF_MASK          = 8'he0;

  localparam int          CTL_GO_BIT       = 0;
  localparam int          CTL_DUAL_BIT     = 1;
  localparam int          CTL_BOOT_BIT     = 8;
  localparam int          CTL_EXT_BIT      = 9;
  localparam int          CTL_FAST_BIT     = 10;
  localparam int          UTIL_DISABLE_BIT = 0;

  localparam logic [7:0]  FR_OPCODE_RESET = 8'h0b;
  localparam logic [7:0]  CMD_LEN_RESET   = 8'h00;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_DESEL = 6'b000010,
    ST_HDR   = 6'b000100,
    ST_RX    = 6'b001000,
    ST_HOLD  = 6'b010000,
    ST_CMD   = 6'b100000
  } state_t;

endpackage : flash_fetch_pkg

// File: verilog/serial_flash_fetch_controller.sv
// What this block does
// - Boot reads flash signature at fixed address
// - Good signature enables external code from zero
// - Port on after reset; disable bit stops it
// - Single read: select, opcode, address, dummy, byte
// - Ready pulse as soon as byte arrives
// - Sequential address keeps select, one more byte
// - Non-sequential address raises flash select
// - Dual read uses programmed opcode register
// - Dual address: top bits zero, rest from bus
// - Dual byte in four clocks, both lines
// - 32-byte cache with base and length
// - Long runs slide base to last 32
// - Cached jump answered in one clock
// - Command buffer, response buffer, length register
// - Go bit: length times eight clocks, self-clearing
// - Response stored after first command byte
// - Bytes beyond command buffer send filler
// - Erase commands use length four
// - Byte program uses length five
// - Single opcode commands use length one
// - Identification read leaves three response bytes
// - Strap caught after reset; both settings give a one-clock half period
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module serial_flash_fetch_controller #(
  parameter int ADDR_W = 24
) (
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST,
  input  wire logic              I_WB_CYC,
  input  wire logic              I_WB_STB,
  input  wire logic              I_WB_WE,
  input  wire logic [7:0]        I_WB_ADR,
  input  wire logic [3:0]        I_WB_SEL,
  input  wire logic [31:0]       I_WB_DAT,
  output logic      [31:0]       O_WB_DAT,
  output logic                   O_WB_ACK,
  input  wire logic              I_FETCH_REQ,
  input  wire logic              I_FETCH_EXTERNAL_DATA_SPACE,
  input  wire logic [ADDR_W-1:0] I_FETCH_ADDR,
  output logic                   O_FETCH_READY,
  output logic      [7:0]        O_FETCH_DATA,
  output logic                   O_BOOT_DONE,
  output logic                   O_EXT_CODE_EN,
  input  wire logic              I_SERIAL_SPEED_STRAP,
  output logic                   O_FLASH_SEL_N,
  output logic                   O_FLASH_CLK,
  output logic                   O_FLASH_DO,
  output logic                   O_FLASH_DO_OE_N,
  input  wire logic              I_FLASH_DO,
  input  wire logic              I_SERIAL_IN_LINE
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  flash_fetch_pkg::state_t state_reg;
  logic [7:0]        cmd_buf_reg [flash_fetch_pkg::CMD_BYTES];
  logic [7:0]        resp_buf_reg [flash_fetch_pkg::CMD_BYTES];
  logic [7:0]        cache_mem [32];
  logic              go_reg;
  logic              dual_en_reg;
  logic              port_disable_reg;
  logic [7:0]        fr_opcode_reg;
  logic [7:0]        cmd_len_reg;
  logic              cmd_done_reg;
  logic              strap_fast_reg;
  logic              strap_taken_reg;
  logic              boot_active_reg;
  logic              boot_ok_reg;
  logic [1:0]        boot_idx_reg;
  logic              ready_reg;
  logic [3:0]        half_cnt_reg;
  logic [39:0]       hdr_reg;
  logic [10:0]       bit_idx_reg;
  logic [10:0]       bit_end_reg;
  logic [7:0]        rx_reg;
  logic [23:0]       cur_addr_reg;
  logic              cur_dual_reg;
  logic              new_run_reg;
  logic [23:0]       base_reg;
  logic [5:0]        len_reg;

  logic              wb_req;
  logic              wb_wr;
  logic [31:0]       rd_next;
  logic              tick;
  logic [3:0]        half_ld;
  logic              req_valid;
  logic              req_dual;
  logic [23:0]       req_addr;
  logic [23:0]       eff_addr;
  logic [23:0]       hit_offs;
  logic              hit;
  logic              seq;
  logic              take;
  logic [7:0]        rx_next;
  logic [7:0]        boot_byte;
  logic [7:0]        cmd_byte_idx;
  logic              cmd_start;

  // Filler beyond the command buffer is driven low
  function automatic logic cmd_bit(input logic [10:0] idx, input logic [7:0] b0,
                                   input logic [7:0] b1, input logic [7:0] b2,
                                   input logic [7:0] b3, input logic [7:0] b4,
                                   input logic [7:0] b5, input logic [7:0] b6,
                                   input logic [7:0] b7);
    logic [7:0] sel_byte;
    sel_byte = 8'h00;
    if (idx[10:6] == 5'h00) begin
      case (idx[5:3])
        3'h0:    sel_byte = b0;
        3'h1:    sel_byte = b1;
        3'h2:    sel_byte = b2;
        3'h3:    sel_byte = b3;
        3'h4:    sel_byte = b4;
        3'h5:    sel_byte = b5;
        3'h6:    sel_byte = b6;
        default: sel_byte = b7;
      endcase
    end
    return sel_byte[3'h7 - idx[2:0]];
  endfunction : cmd_bit

  // ==========================================================================
  // Wishbone slave: ack one cycle after request, write at the ack edge
  // ==========================================================================
  assign wb_req = I_WB_CYC & I_WB_STB;
  assign wb_wr  = wb_req & I_WB_WE & O_WB_ACK & I_WB_SEL[0];

  always_comb begin
    rd_next = 32'h0000_0000;
    if ((I_WB_ADR & flash_fetch_pkg::BUF_MASK) == flash_fetch_pkg::ADDR_CMD_BUF) begin
      rd_next[7:0] = cmd_buf_reg[I_WB_ADR[4:2]];
    end else if ((I_WB_ADR & flash_fetch_pkg::BUF_MASK) == flash_fetch_pkg::ADDR_RESP_BUF) begin
      rd_next[7:0] = resp_buf_reg[I_WB_ADR[4:2]];
    end else begin
      case (I_WB_ADR)
        flash_fetch_pkg::ADDR_PORT_CONTROL: begin
          rd_next[flash_fetch_pkg::CTL_GO_BIT]   = go_reg;
          rd_next[flash_fetch_pkg::CTL_DUAL_BIT] = dual_en_reg;
          rd_next[flash_fetch_pkg::CTL_BOOT_BIT] = O_BOOT_DONE;
          rd_next[flash_fetch_pkg::CTL_EXT_BIT]  = O_EXT_CODE_EN;
          rd_next[flash_fetch_pkg::CTL_FAST_BIT] = strap_fast_reg;
        end
        flash_fetch_pkg::ADDR_UTIL_CONFIG: rd_next[flash_fetch_pkg::UTIL_DISABLE_BIT] = port_disable_reg;
        flash_fetch_pkg::ADDR_FR_OPCODE:   rd_next[7:0] = fr_opcode_reg;
        flash_fetch_pkg::ADDR_CMD_LEN:     rd_next[7:0] = cmd_len_reg;
        default:                           rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end else begin
      O_WB_ACK <= wb_req & ~O_WB_ACK;
      O_WB_DAT <= rd_next;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      dual_en_reg      <= 1'b0;
      port_disable_reg <= 1'b0;
      fr_opcode_reg    <= flash_fetch_pkg::FR_OPCODE_RESET;
      cmd_len_reg      <= flash_fetch_pkg::CMD_LEN_RESET;
    end else if (wb_wr) begin
      case (I_WB_ADR)
        flash_fetch_pkg::ADDR_PORT_CONTROL: dual_en_reg <= I_WB_DAT[flash_fetch_pkg::CTL_DUAL_BIT];
        flash_fetch_pkg::ADDR_UTIL_CONFIG:
          port_disable_reg <= I_WB_DAT[flash_fetch_pkg::UTIL_DISABLE_BIT];
        flash_fetch_pkg::ADDR_FR_OPCODE:    fr_opcode_reg <= I_WB_DAT[7:0];
        flash_fetch_pkg::ADDR_CMD_LEN:      cmd_len_reg <= I_WB_DAT[7:0];
        default: ;
      endcase
    end
  end

  // Set by a write wins over the clear from a finishing transfer
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      go_reg <= 1'b0;
    end else if (wb_wr && I_WB_ADR == flash_fetch_pkg::ADDR_PORT_CONTROL
                 && I_WB_DAT[flash_fetch_pkg::CTL_GO_BIT]) begin
      go_reg <= 1'b1;
    end else if (cmd_done_reg) begin
      go_reg <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < flash_fetch_pkg::CMD_BYTES; gi++) begin : g_cmd_buf
      always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
          cmd_buf_reg[gi] <= 8'h00;
        end else if (wb_wr && (I_WB_ADR & flash_fetch_pkg::BUF_MASK) == flash_fetch_pkg::ADDR_CMD_BUF
                     && I_WB_ADR[4:2] == 3'(gi)) begin
          cmd_buf_reg[gi] <= I_WB_DAT[7:0];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Strap capture and boot signature check
  // ==========================================================================
  assign boot_byte = 8'(flash_fetch_pkg::BOOT_SIG >> {~boot_idx_reg, 3'b000});

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      strap_taken_reg <= 1'b0;
      strap_fast_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_fast_reg  <= I_SERIAL_SPEED_STRAP;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      boot_active_reg <= 1'b1;
      boot_ok_reg     <= 1'b1;
      boot_idx_reg    <= 2'h0;
      O_BOOT_DONE     <= 1'b0;
      O_EXT_CODE_EN   <= 1'b0;
    end else if (boot_active_reg && port_disable_reg) begin
      // No port, no image: fall back to internal code
      boot_active_reg <= 1'b0;
      O_BOOT_DONE     <= 1'b1;
    end else if (boot_active_reg && ready_reg) begin
      boot_idx_reg <= boot_idx_reg + 2'h1;
      if (rx_reg != boot_byte) begin
        boot_ok_reg <= 1'b0;
      end
      if (boot_idx_reg == 2'h3) begin
        boot_active_reg <= 1'b0;
        O_BOOT_DONE     <= 1'b1;
        O_EXT_CODE_EN   <= boot_ok_reg & (rx_reg == boot_byte);
      end
    end
  end

  // ==========================================================================
  // Request decode and fetch cache lookup
  // ==========================================================================
  assign req_valid = boot_active_reg ? strap_taken_reg
                                     : I_FETCH_REQ & O_BOOT_DONE & (O_EXT_CODE_EN | I_FETCH_EXTERNAL_DATA_SPACE);
  assign req_dual  = ~boot_active_reg & I_FETCH_EXTERNAL_DATA_SPACE & dual_en_reg;
  assign req_addr  = boot_active_reg ? flash_fetch_pkg::BOOT_SIG_ADDR + 24'(boot_idx_reg)
                                     : 24'(I_FETCH_ADDR);
  assign eff_addr  = req_dual ? {flash_fetch_pkg::DUAL_ADDR_HIGH, req_addr[16:0]}
                              : req_addr;
  assign hit_offs  = eff_addr - base_reg;
  assign hit       = hit_offs < {18'h00000, len_reg};
  assign seq       = (eff_addr == cur_addr_reg + 24'h000001) && (req_dual == cur_dual_reg);
  assign cmd_start = go_reg & ~cmd_done_reg;
  assign take      = req_valid & ~ready_reg & ~cmd_start;
  assign half_ld   = strap_fast_reg ? flash_fetch_pkg::HALF_FAST_LD
                                    : flash_fetch_pkg::HALF_SLOW_LD;
  assign tick      = (half_cnt_reg == 4'h0);
  assign rx_next   = cur_dual_reg && state_reg == flash_fetch_pkg::ST_RX
                     ? {rx_reg[5:0], I_SERIAL_IN_LINE, I_FLASH_DO}
                     : {rx_reg[6:0], I_SERIAL_IN_LINE};
  assign cmd_byte_idx = bit_idx_reg[10:3];

  // ==========================================================================
  // Serial engine
  // ==========================================================================
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_reg       <= flash_fetch_pkg::ST_IDLE;
      O_FLASH_SEL_N   <= 1'b1;
      O_FLASH_CLK     <= 1'b0;
      O_FLASH_DO      <= 1'b0;
      O_FLASH_DO_OE_N <= 1'b0;
      O_FETCH_READY   <= 1'b0;
      O_FETCH_DATA    <= 8'h00;
      ready_reg       <= 1'b0;
      cmd_done_reg    <= 1'b0;
      half_cnt_reg    <= 4'h0;
      hdr_reg         <= 40'h00_0000_0000;
      bit_idx_reg     <= 11'h000;
      bit_end_reg     <= 11'h000;
      rx_reg          <= 8'h00;
      cur_addr_reg    <= 24'h000000;
      cur_dual_reg    <= 1'b0;
      new_run_reg     <= 1'b0;
      base_reg        <= 24'h000000;
      len_reg         <= 6'h00;
    end else begin
      ready_reg     <= 1'b0;
      O_FETCH_READY <= 1'b0;
      cmd_done_reg  <= 1'b0;
      half_cnt_reg  <= tick ? half_ld : half_cnt_reg - 4'h1;
      if (port_disable_reg) begin
        state_reg       <= flash_fetch_pkg::ST_IDLE;
        O_FLASH_SEL_N   <= 1'b1;
        O_FLASH_CLK     <= 1'b0;
        O_FLASH_DO_OE_N <= 1'b0;
        cmd_done_reg    <= go_reg & ~cmd_done_reg;
      end else begin
        case (state_reg)
          flash_fetch_pkg::ST_IDLE, flash_fetch_pkg::ST_HOLD: begin
            if (cmd_start && state_reg == flash_fetch_pkg::ST_HOLD) begin
              O_FLASH_SEL_N <= 1'b1;
              state_reg     <= flash_fetch_pkg::ST_DESEL;
            end else if (cmd_start) begin
              if (cmd_len_reg == 8'h00) begin
                cmd_done_reg <= 1'b1;
              end else begin
                O_FLASH_SEL_N <= 1'b0;
                O_FLASH_DO    <= cmd_buf_reg[0][7];
                bit_idx_reg   <= 11'h000;
                bit_end_reg   <= {cmd_len_reg, 3'b000};
                len_reg       <= 6'h00;
                half_cnt_reg  <= half_ld;
                state_reg     <= flash_fetch_pkg::ST_CMD;
              end
            end else if (take && hit) begin
              ready_reg     <= 1'b1;
              O_FETCH_READY <= ~boot_active_reg;
              O_FETCH_DATA  <= cache_mem[eff_addr[4:0]];
              rx_reg        <= cache_mem[eff_addr[4:0]];
              if (state_reg == flash_fetch_pkg::ST_HOLD) begin
                O_FLASH_SEL_N <= 1'b1;
                state_reg     <= flash_fetch_pkg::ST_DESEL;
              end
            end else if (take && state_reg == flash_fetch_pkg::ST_HOLD && seq) begin
              cur_addr_reg    <= eff_addr;
              new_run_reg     <= 1'b0;
              bit_idx_reg     <= 11'h000;
              bit_end_reg     <= cur_dual_reg ? flash_fetch_pkg::RX_BITS_DUAL
                                              : flash_fetch_pkg::RX_BITS_SINGLE;
              O_FLASH_DO_OE_N <= cur_dual_reg;
              half_cnt_reg    <= half_ld;
              state_reg       <= flash_fetch_pkg::ST_RX;
            end else if (take && state_reg == flash_fetch_pkg::ST_HOLD) begin
              O_FLASH_SEL_N <= 1'b1;
              state_reg     <= flash_fetch_pkg::ST_DESEL;
            end else if (take) begin
              O_FLASH_SEL_N <= 1'b0;
              hdr_reg       <= {req_dual ? fr_opcode_reg : flash_fetch_pkg::OP_FAST_READ,
                                eff_addr, 8'h00};
              O_FLASH_DO    <= req_dual ? fr_opcode_reg[7] : flash_fetch_pkg::OP_FAST_READ[7];
              cur_addr_reg  <= eff_addr;
              cur_dual_reg  <= req_dual;
              new_run_reg   <= 1'b1;
              base_reg      <= eff_addr;
              len_reg       <= 6'h00;
              bit_idx_reg   <= 11'h000;
              bit_end_reg   <= flash_fetch_pkg::HDR_BITS;
              half_cnt_reg  <= half_ld;
              state_reg     <= flash_fetch_pkg::ST_HDR;
            end
          end

          // One idle cycle with select high before any new frame
          flash_fetch_pkg::ST_DESEL: begin
            O_FLASH_DO_OE_N <= 1'b0;
            state_reg       <= flash_fetch_pkg::ST_IDLE;
          end

          flash_fetch_pkg::ST_HDR: begin
            if (tick && !O_FLASH_CLK) begin
              O_FLASH_CLK <= 1'b1;
            end else if (tick) begin
              O_FLASH_CLK <= 1'b0;
              if (bit_idx_reg == bit_end_reg - 11'h001) begin
                bit_idx_reg     <= 11'h000;
                bit_end_reg     <= cur_dual_reg ? flash_fetch_pkg::RX_BITS_DUAL
                                                : flash_fetch_pkg::RX_BITS_SINGLE;
                O_FLASH_DO_OE_N <= cur_dual_reg;
                state_reg       <= flash_fetch_pkg::ST_RX;
              end else begin
                bit_idx_reg <= bit_idx_reg + 11'h001;
                hdr_reg     <= {hdr_reg[38:0], 1'b0};
                O_FLASH_DO  <= hdr_reg[38];
              end
            end
          end

          flash_fetch_pkg::ST_RX: begin
            if (tick && !O_FLASH_CLK) begin
              O_FLASH_CLK <= 1'b1;
              rx_reg      <= rx_next;
            end else if (tick) begin
              O_FLASH_CLK <= 1'b0;
              if (bit_idx_reg == bit_end_reg - 11'h001) begin
                ready_reg     <= 1'b1;
                O_FETCH_READY <= ~boot_active_reg;
                O_FETCH_DATA  <= rx_reg;
                cache_mem[cur_addr_reg[4:0]] <= rx_reg;
                if (len_reg == flash_fetch_pkg::CACHE_BYTES) begin
                  base_reg <= base_reg + 24'h000001;
                end else begin
                  len_reg <= len_reg + 6'h01;
                end
                O_FLASH_DO_OE_N <= 1'b0;
                state_reg       <= flash_fetch_pkg::ST_HOLD;
              end else begin
                bit_idx_reg <= bit_idx_reg + 11'h001;
              end
            end
          end

          flash_fetch_pkg::ST_CMD: begin
            if (tick && !O_FLASH_CLK) begin
              O_FLASH_CLK <= 1'b1;
              rx_reg      <= rx_next;
            end else if (tick) begin
              O_FLASH_CLK <= 1'b0;
              if (bit_idx_reg[2:0] == 3'h7 && cmd_byte_idx != 8'h00
                  && cmd_byte_idx <= 8'(flash_fetch_pkg::CMD_BYTES)) begin
                resp_buf_reg[3'(cmd_byte_idx - 8'h01)] <= rx_reg;
              end
              if (bit_idx_reg == bit_end_reg - 11'h001) begin
                O_FLASH_SEL_N <= 1'b1;
                cmd_done_reg  <= 1'b1;
                state_reg     <= flash_fetch_pkg::ST_DESEL;
              end else begin
                bit_idx_reg <= bit_idx_reg + 11'h001;
                O_FLASH_DO  <= cmd_bit(bit_idx_reg + 11'h001, cmd_buf_reg[0], cmd_buf_reg[1],
                                       cmd_buf_reg[2], cmd_buf_reg[3], cmd_buf_reg[4],
                                       cmd_buf_reg[5], cmd_buf_reg[6], cmd_buf_reg[7]);
              end
            end
          end

          default: begin
            O_FLASH_SEL_N <= 1'b1;
            O_FLASH_CLK   <= 1'b0;
            state_reg     <= flash_fetch_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule : serial_flash_fetch_controller

`default_nettype wire

// File: verif/flash_fetch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module flash_fetch_assertions (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic O_WB_ACK,
  input wire logic O_FETCH_READY,
  input wire logic O_BOOT_DONE,
  input wire logic O_EXT_CODE_EN,
  input wire logic O_FLASH_SEL_N,
  input wire logic O_FLASH_CLK
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  a_clk_idle: assert property (O_FLASH_SEL_N |-> !O_FLASH_CLK) else $error("clk not idle");
  a_clk_phase: assert property (O_FLASH_CLK |=> !O_FLASH_CLK) else $error("clk phase");
  a_sel_gap: assert property ($rose(O_FLASH_SEL_N) |=> O_FLASH_SEL_N) else $error("sel gap");
  a_ready_pulse: assert property (O_FETCH_READY |=> !O_FETCH_READY) else $error("ready");
  a_boot_first: assert property (!O_BOOT_DONE |-> !O_FETCH_READY) else $error("early");
  a_ext_boot: assert property (O_EXT_CODE_EN |-> O_BOOT_DONE) else $error("ext early");
  a_ack_answer: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
    else $error("no ack");
  a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack long");
endmodule : flash_fetch_assertions
`default_nettype wire

// File: verif/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter logic [23:0] ID_WORD = 24'ha1b2c3 // Arbitrary id value
) (
  input  wire logic sel_n,
  input  wire logic clk,
  input  wire logic din,
  output logic      so = 0,
  output logic      dq1 = 0
);
  logic [31:0] sh = 0;
  logic [7:0]  op, d;
  logic [23:0] a;
  int          n = 0, k;
  function automatic logic [7:0] mem(input logic [23:0] x);
    return (x >= 24'h00fffa && x <= 24'h00fffd) ?
      8'(flash_fetch_pkg::BOOT_SIG >> (8 * (24'h00fffd - x))) : x[7:0] ^ x[23:16] ^ 8'h5a;
  endfunction : mem
  always @(posedge clk or posedge sel_n) if (sel_n) n <= 0; else begin
    sh <= {sh[30:0], din};
    n <= n + 1;
  end
  // Data changes on the falling clock so it is settled at the next rise
  always @(negedge clk) if (!sel_n) begin
    if (n == 8) op = sh[7:0];
    if (n == 32) a = sh[23:0];
    k = n - 40;
    if (op == 8'h3b && n >= 40) begin d = mem(a + 24'(k / 4)); {so, dq1} <= d[7 - 2 * (k % 4) -: 2]; end
    else if (op == 8'h0b && n >= 40) begin d = mem(a + 24'(k / 8)); so <= d[7 - k % 8]; end
    else if (op != 8'h0b && op != 8'h3b && n >= 8) begin
      k = n - 8;
      d = (k < 24) ? ID_WORD[23 - 8 * (k / 8) -: 8] : 8'h00;
      so <= d[7 - k % 8];
    end
  end
  // Released lines must not hold the last bit
  always @(posedge sel_n) begin so <= ~so; dq1 <= ~dq1; end
endmodule : flash_model
`default_nettype wire

// File: verif/serial_flash_fetch_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_fetch_controller_bench;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, req = 0, xd = 0;
  logic [7:0] adr = 0, fd, ops [4] = '{8'h20, 8'h02, 8'h06, 8'h9f};
  logic [31:0] wdat = 0, rd, rdat;
  logic [23:0] fa = 0;
  logic ack, rdy, bd, ext, seln, sck, sdo, oen, dq1, si;
  int n_mismatch = 0, n_compared = 0, cyc_n = 0, n_sck = 0, lat, lens [4] = '{4, 5, 1, 4};
  wire logic fdo = oen ? dq1 : sdo;
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc_n == 60000) begin n_mismatch++; stop_test(); end
  always @(posedge sck) n_sck++;
  serial_flash_fetch_controller uut (.I_CLK_SYS(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_FETCH_REQ(req), .I_FETCH_EXTERNAL_DATA_SPACE(xd), .I_FETCH_ADDR(fa), .O_FETCH_READY(rdy), .O_FETCH_DATA(fd),
    .O_BOOT_DONE(bd), .O_EXT_CODE_EN(ext), .I_SERIAL_SPEED_STRAP(1'b0), .O_FLASH_SEL_N(seln),
    .O_FLASH_CLK(sck), .O_FLASH_DO(sdo), .O_FLASH_DO_OE_N(oen), .I_FLASH_DO(fdo), .I_SERIAL_IN_LINE(si));
  flash_model fm (.sel_n(seln), .clk(sck), .din(fdo), .so(si), .dq1(dq1));
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[23:16] ^ 8'h5a;
  endfunction : mem
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin n_mismatch++; $display("[FAIL] %s expected %h seen %h", what, exp, seen); end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat; cyc <= 0; stb <= 0; we <= 0;
  endtask : wb
  task automatic fetch(input logic x, input logic [23:0] a);
    @(posedge clk); req <= 1; xd <= x; fa <= a; lat = 0;
    do begin @(posedge clk); lat++; end while (rdy !== 1'b1);
    req <= 0;
  endtask : fetch
  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge clk); rst <= 0;
    while (bd !== 1'b1) @(posedge clk);
    chk("ext code", ext, 1);
    wb(0, 8'h00, 0); chk("status", rd[10:8], 3'b011);
    wb(0, 8'h08, 0); chk("opcode", rd[7:0], 8'h0b);
    wb(0, 8'h10, 0); chk("unmapped", rd, 0);
    for (int i = 0; i < 40; i++) begin fetch(0, 24'(i)); chk("seq", fd, mem(24'(i))); end
    fetch(0, 24'd20); chk("hit", {lat, fd}, {32'd2, mem(24'd20)});
    fetch(0, 24'd5); chk("evicted", {lat > 3, fd}, {1'b1, mem(24'd5)});
    $display("fetch test done");
    wb(1, 8'h08, 8'h3b); wb(1, 8'h00, 2);
    fetch(1, 24'hfe0123); chk("dual", fd, mem(24'h000123));
    fetch(1, 24'hfe0124); chk("dual seq", fd, mem(24'h000124));
    $display("dual test done");
    for (int k = 0; k < 4; k++) begin
      wb(1, 8'h20, ops[k]); wb(1, 8'h0c, lens[k]); n_sck = 0; wb(1, 8'h00, 1);
      do wb(0, 8'h00, 0); while (rd[0] !== 1'b0);
      chk("clocks", n_sck, lens[k] * 8);
      chk("desel", seln, 1);
    end
    for (int j = 0; j < 3; j++) begin wb(0, 8'(8'h40 + 4 * j), 0); chk("id", rd[7:0], fm.ID_WORD[23 - 8 * j -: 8]); end
    $display("command test done");
    wb(1, 8'h04, 1); @(posedge clk); req <= 1; fa <= 24'd200;
    repeat (300) @(posedge clk); chk("disabled", {seln, rdy}, 2'b10);
    req <= 0;
    $display("disable test done");
    stop_test();
  end
endmodule : serial_flash_fetch_controller_bench
bind serial_flash_fetch_controller flash_fetch_assertions chk_i (.*);
`default_nettype wire
